// *** core/ocl_cfg.svh ***
// constants of the display-ram loader: register indices, field layout, reset values
// included by the package, the loader, its ram and rom, and the bench files; definitions only
`ifndef OCL_CFG_SVH
`define OCL_CFG_SVH
`define OCL_AXI_AW 12
`define OCL_IDX_ATTR 8'h99
`define OCL_IDX_CODE 8'h9a
`define OCL_IDX_PTR 8'h9b
`define OCL_IDX_FADDR 8'h9c
`define OCL_IDX_FDATA 8'h9d
`define OCL_IDX_STAT 8'h9e
`define OCL_BYTE_ADDR(i) {2'b00, (i), 2'b00}
`define OCL_ATTR_W 5
`define OCL_CODE_W 7
`define OCL_PTR_W 8
`define OCL_WORD_W 12
`define OCL_ROW_W 5
`define OCL_CODE_LSB 5
`define OCL_RAM_WORDS 192
`define OCL_CODE_CR 7'h7e
`define OCL_CODE_SPACE 7'h7f
`define OCL_SPACE_SEL_BIT 0
`define OCL_FONT_BYTES 13'd38
`define OCL_ROW_BYTES 13'd2
`define OCL_ROW_FIRST_VIS 5'd1
`define OCL_ROW_LAST_VIS 5'd18
`define OCL_ROM_AW 13
`define OCL_ROM_HALF_WORDS 4096
`define OCL_ROM_HALF_BIT 12
`define OCL_SUB_NWSHADOW 2'b01
`define OCL_SUB_BORDER 2'b11
`define OCL_RST_ATTR 5'h00
`define OCL_RST_CODE 7'h00
`define OCL_RST_PTR 8'h00
`define OCL_RST_FADDR 13'h0000
`define OCL_STAT_BUSY 0
`define OCL_STAT_DROP 1
`define OCL_RESP_OKAY 2'b00
`define OCL_RESP_SLVERR 2'b10
`endif

// *** core/ocl_disp_ram.sv ***
// display character ram, 192 words of code and attribute
// single port: the display fetch wins, a pending store waits
`timescale 1ns/10ps
`default_nettype none
`include "ocl_cfg.svh"
module ocl_disp_ram (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // loader side
  ocl_mem_if.store mem
);
  import ocl_pkg::*;
  logic [`OCL_WORD_W-1:0] cells [`OCL_RAM_WORDS];
  logic in_range;

  assign in_range = mem.wr_addr < 8'(`OCL_RAM_WORDS);
  assign mem.wr_ack = mem.wr_en && !mem.rd_en;

  always_ff @(posedge aclk) begin
    if (mem.wr_ack && in_range) begin
      cells[mem.wr_addr] <= mem.wr_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem.rd_data <= '0;
      mem.rd_valid <= 1'b0;
    end else begin
      mem.rd_valid <= mem.rd_en;
      if (mem.rd_en) begin
        mem.rd_data <= (mem.rd_addr < 8'(`OCL_RAM_WORDS)) ? cells[mem.rd_addr] : '0;
      end
    end
  end
endmodule : ocl_disp_ram
`default_nettype wire

// *** core/ocl_font_rom.sv ***
// character font rom in two 4k halves, image written byte by byte by the loader
// a row read returns 12 dots, leftmost dot in the top bit
`timescale 1ns/10ps
`default_nettype none
`include "ocl_cfg.svh"
module ocl_font_rom (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // loader side
  ocl_mem_if.store mem
);
  import ocl_pkg::*;
  logic [7:0] lower_half [`OCL_ROM_HALF_WORDS];
  logic [7:0] upper_half [`OCL_ROM_HALF_WORDS];
  logic [`OCL_ROM_AW-1:0] row_addr;
  logic [`OCL_ROM_AW-1:0] next_addr;

  function automatic logic [7:0] rom_byte(input logic [`OCL_ROM_AW-1:0] a);
    return a[`OCL_ROM_HALF_BIT] ? upper_half[a[11:0]] : lower_half[a[11:0]];
  endfunction : rom_byte

  assign mem.wr_ack = mem.wr_en;
  assign row_addr = ocl_font_addr(mem.rd_addr[11:5], mem.rd_addr[4:0]);
  assign next_addr = row_addr + 13'h0001;

  always_ff @(posedge aclk) begin
    if (mem.wr_en) begin
      if (mem.wr_addr[`OCL_ROM_HALF_BIT]) begin
        upper_half[mem.wr_addr[11:0]] <= mem.wr_data;
      end else begin
        lower_half[mem.wr_addr[11:0]] <= mem.wr_data;
      end
    end
  end

  // dots: first byte high then low nibble, then high nibble of the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem.rd_data <= '0;
      mem.rd_valid <= 1'b0;
    end else begin
      mem.rd_valid <= mem.rd_en;
      if (mem.rd_en) begin
        mem.rd_data <= {rom_byte(row_addr), 4'(rom_byte(next_addr) >> 4)};
      end
    end
  end
endmodule : ocl_font_rom
`default_nettype wire

// *** core/ocl_loader.sv ***
// display-ram loader: axi4-lite register slave, auto-store on code write,
// display word fetch and font row fetch for the display engine
// assumes a display engine issuing fetches and a host loading the font image
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "ocl_cfg.svh"
module ocl_loader (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [`OCL_AXI_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [`OCL_AXI_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // display word fetch
  input wire logic disp_rd_en,
  input wire logic [`OCL_PTR_W-1:0] disp_rd_addr,
  output logic [`OCL_WORD_W-1:0] disp_word,
  output ocl_pkg::ocl_kind_type disp_kind,
  output logic disp_row_end,
  output logic disp_space_clear,
  output logic disp_valid,
  // font row fetch
  input wire logic font_rd_en,
  input wire logic [`OCL_CODE_W-1:0] font_code,
  input wire logic [`OCL_ROW_W-1:0] font_row,
  input wire logic [1:0] font_submode,
  output logic [`OCL_WORD_W-1:0] font_dots,
  output logic font_carry,
  output logic font_valid
);
  import ocl_pkg::*;

  ocl_mem_if #(.WAW(`OCL_PTR_W), .WDW(`OCL_WORD_W), .RAW(`OCL_PTR_W),
               .RDW(`OCL_WORD_W)) ram_bus ();
  ocl_mem_if #(.WAW(`OCL_ROM_AW), .WDW(8), .RAW(`OCL_CODE_W + `OCL_ROW_W),
               .RDW(`OCL_WORD_W)) rom_bus ();

  ocl_disp_ram u_ram (
    .aclk(aclk),
    .aresetn(aresetn),
    .mem(ram_bus.store)
  );

  ocl_font_rom u_rom (
    .aclk(aclk),
    .aresetn(aresetn),
    .mem(rom_bus.store)
  );

  function automatic ocl_reg_type reg_sel(input logic [`OCL_AXI_AW-1:0] a);
    case (a)
      `OCL_BYTE_ADDR(`OCL_IDX_ATTR): return OCL_REG_ATTR;
      `OCL_BYTE_ADDR(`OCL_IDX_CODE): return OCL_REG_CODE;
      `OCL_BYTE_ADDR(`OCL_IDX_PTR): return OCL_REG_PTR;
      `OCL_BYTE_ADDR(`OCL_IDX_FADDR): return OCL_REG_FADDR;
      `OCL_BYTE_ADDR(`OCL_IDX_FDATA): return OCL_REG_FDATA;
      `OCL_BYTE_ADDR(`OCL_IDX_STAT): return OCL_REG_STAT;
      default: return OCL_REG_NONE;
    endcase
  endfunction : reg_sel

  function automatic logic is_shadow(input logic [1:0] sub);
    return (sub == `OCL_SUB_NWSHADOW) || (sub == `OCL_SUB_BORDER);
  endfunction : is_shadow

  // register state
  logic [`OCL_ATTR_W-1:0] attr_reg;
  logic [`OCL_CODE_W-1:0] code_reg;
  logic [`OCL_PTR_W-1:0] ptr_reg;
  logic [`OCL_ROM_AW-1:0] faddr_reg;
  logic drop_reg;

  // write channel state
  ocl_wstate_type wstate_reg, wstate_next;
  logic aw_have_reg, aw_have_next;
  logic w_have_reg, w_have_next;
  logic [`OCL_AXI_AW-1:0] waddr_reg;
  logic [`OCL_ROM_AW-1:0] wdata_reg;
  logic wstrb0_reg;
  logic commit, wr_ok, store_req, store_ack;
  ocl_reg_type wsel;
  ocl_reg_type rsel_reg;

  // font pipeline
  logic [`OCL_ROW_W-1:0] frow_pipe;
  logic [1:0] fsub_pipe;
  logic row_visible;

  assign wsel = reg_sel(waddr_reg);
  assign commit = (wstate_reg == OCL_WR_IDLE) && aw_have_reg && w_have_reg;
  // a write without the low byte lane changes nothing but still answers
  assign wr_ok = commit && (wsel != OCL_REG_NONE) && wstrb0_reg;
  assign store_req = (wstate_reg == OCL_WR_STORE);
  assign store_ack = store_req && ram_bus.wr_ack;

  always_comb begin
    aw_have_next = commit ? 1'b0 : (aw_have_reg | (s_axi_awvalid && s_axi_awready));
    w_have_next = commit ? 1'b0 : (w_have_reg | (s_axi_wvalid && s_axi_wready));
    wstate_next = wstate_reg;
    case (wstate_reg)
      OCL_WR_IDLE: begin
        if (commit) begin
          wstate_next = (wr_ok && wsel == OCL_REG_CODE) ? OCL_WR_STORE : OCL_WR_RESP;
        end
      end
      OCL_WR_STORE: begin
        if (store_ack) begin
          wstate_next = OCL_WR_RESP;
        end
      end
      OCL_WR_RESP: begin
        if (s_axi_bvalid && s_axi_bready) begin
          wstate_next = OCL_WR_IDLE;
        end
      end
      default: wstate_next = OCL_WR_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wstate_reg <= OCL_WR_IDLE;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
    end else begin
      wstate_reg <= wstate_next;
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      // no new write is taken while a store waits, so nothing is overrun
      s_axi_awready <= (wstate_next == OCL_WR_IDLE) && !aw_have_next;
      s_axi_wready <= (wstate_next == OCL_WR_IDLE) && !w_have_next;
      s_axi_bvalid <= (wstate_next == OCL_WR_RESP);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      waddr_reg <= '0;
      wdata_reg <= '0;
      wstrb0_reg <= 1'b0;
      s_axi_bresp <= `OCL_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        waddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_reg <= s_axi_wdata[`OCL_ROM_AW-1:0];
        wstrb0_reg <= s_axi_wstrb[0];
      end
      if (commit) begin
        s_axi_bresp <= (wsel == OCL_REG_NONE) ? `OCL_RESP_SLVERR : `OCL_RESP_OKAY;
      end
    end
  end

  // attribute: reserved top bits are never stored, kept across stores
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      attr_reg <= `OCL_RST_ATTR;
    end else if (wr_ok && wsel == OCL_REG_ATTR) begin
      attr_reg <= wdata_reg[`OCL_ATTR_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      code_reg <= `OCL_RST_CODE;
    end else if (wr_ok && wsel == OCL_REG_CODE) begin
      code_reg <= wdata_reg[`OCL_CODE_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr_reg <= `OCL_RST_PTR;
    end else if (wr_ok && wsel == OCL_REG_PTR) begin
      ptr_reg <= wdata_reg[`OCL_PTR_W-1:0];
    end else if (store_ack) begin
      ptr_reg <= ptr_reg + 8'h01;
    end
  end

  // sticky until the next store; set from the store that missed the ram
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drop_reg <= 1'b0;
    end else if (store_ack) begin
      drop_reg <= ptr_reg >= 8'(`OCL_RAM_WORDS);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      faddr_reg <= `OCL_RST_FADDR;
    end else if (wr_ok && wsel == OCL_REG_FADDR) begin
      faddr_reg <= wdata_reg;
    end else if (wr_ok && wsel == OCL_REG_FDATA) begin
      faddr_reg <= faddr_reg + 13'h0001;
    end
  end

  assign ram_bus.wr_en = store_req;
  assign ram_bus.wr_addr = ptr_reg;
  assign ram_bus.wr_data = {code_reg, attr_reg};
  assign ram_bus.rd_en = disp_rd_en;
  assign ram_bus.rd_addr = disp_rd_addr;
  assign rom_bus.wr_en = wr_ok && (wsel == OCL_REG_FDATA);
  assign rom_bus.wr_addr = faddr_reg;
  assign rom_bus.wr_data = wdata_reg[7:0];
  assign rom_bus.rd_en = font_rd_en;
  assign rom_bus.rd_addr = {font_code, font_row};

  // read channel: one read at a time, answered the cycle after it is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `OCL_RESP_OKAY;
      rsel_reg <= OCL_REG_NONE;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      rsel_reg <= reg_sel(s_axi_araddr);
      s_axi_rresp <= `OCL_RESP_OKAY;
      case (reg_sel(s_axi_araddr))
        OCL_REG_ATTR: s_axi_rdata <= 32'({attr_reg});
        OCL_REG_CODE: s_axi_rdata <= 32'({code_reg});
        OCL_REG_PTR: s_axi_rdata <= 32'({ptr_reg});
        OCL_REG_FADDR: s_axi_rdata <= 32'({faddr_reg});
        OCL_REG_STAT: s_axi_rdata <= 32'({drop_reg, store_req});
        OCL_REG_FDATA: s_axi_rdata <= 32'h0000_0000;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `OCL_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // display word: type decides how the attribute bits are read downstream
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      disp_word <= '0;
      disp_kind <= OCL_KIND_CUSTOMER;
      disp_row_end <= 1'b0;
      disp_space_clear <= 1'b0;
      disp_valid <= 1'b0;
    end else begin
      disp_valid <= ram_bus.rd_valid;
      if (ram_bus.rd_valid) begin
        disp_word <= ram_bus.rd_data;
        disp_kind <= ocl_classify(ram_bus.rd_data[11:`OCL_CODE_LSB]);
        disp_row_end <= ocl_classify(ram_bus.rd_data[11:`OCL_CODE_LSB]) == OCL_KIND_CR;
        disp_space_clear <= (ocl_classify(ram_bus.rd_data[11:`OCL_CODE_LSB]) == OCL_KIND_SPACE)
                            && ram_bus.rd_data[`OCL_SPACE_SEL_BIT];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frow_pipe <= '0;
      fsub_pipe <= '0;
    end else if (font_rd_en) begin
      frow_pipe <= font_row;
      fsub_pipe <= font_submode;
    end
  end

  // row zero only feeds shadow sub-modes; rows past eighteen never show
  assign row_visible = ((frow_pipe >= `OCL_ROW_FIRST_VIS) && (frow_pipe <= `OCL_ROW_LAST_VIS))
                       || ((frow_pipe == 5'd0) && is_shadow(fsub_pipe));

  // no clipping at the cell edge in any sub-mode; in shadow sub-modes the rightmost dot also goes out on font_carry
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      font_dots <= '0;
      font_carry <= 1'b0;
      font_valid <= 1'b0;
    end else begin
      font_valid <= rom_bus.rd_valid;
      if (rom_bus.rd_valid) begin
        font_dots <= row_visible ? rom_bus.rd_data : '0;
        font_carry <= row_visible && is_shadow(fsub_pipe) && rom_bus.rd_data[0];
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_ptr_load: assert property (wr_ok && wsel == OCL_REG_PTR |=>
    ptr_reg == $past(wdata_reg[7:0])) else $error("pointer not loaded");
  a_code_read: assert property (s_axi_rvalid && rsel_reg == OCL_REG_CODE |->
    s_axi_rdata[31:7] == 25'h0) else $error("code read upper bits set");
  a_attr_read: assert property (s_axi_rvalid && rsel_reg == OCL_REG_ATTR |->
    s_axi_rdata[31:5] == 27'h0) else $error("attribute reserved bits set");
  a_code_store: assert property (wr_ok && wsel == OCL_REG_CODE |=>
    store_req && ram_bus.wr_data[11:5] == $past(wdata_reg[6:0]) && ram_bus.wr_addr == ptr_reg)
    else $error("code write did not start store");
  a_ptr_step: assert property (store_ack |=>
    ptr_reg == $past(ptr_reg) + 8'h01 && s_axi_bvalid)
    else $error("pointer not advanced after store");
  a_ptr_wrap: assert property (store_ack && ptr_reg == 8'hff |=>
    ptr_reg == 8'h00) else $error("pointer did not wrap");
  a_attr_kept: assert property (store_ack |=>
    attr_reg == $past(attr_reg) && s_axi_bvalid) else $error("attribute lost on store");
  a_store_waits: assert property (store_req && disp_rd_en |=>
    store_req && ptr_reg == $past(ptr_reg)) else $error("store not held during fetch");
  a_store_done: assert property (store_req && !disp_rd_en |=>
    !store_req ##0 s_axi_bvalid) else $error("granted store did not finish");
  a_drop_flag: assert property (store_ack && ptr_reg >= 8'd192 |=>
    drop_reg) else $error("out of range store not flagged");
  a_cr_decode: assert property (ram_bus.rd_valid && ram_bus.rd_data[11:5] == 7'h7e |=>
    disp_valid && disp_row_end && disp_kind == OCL_KIND_CR) else $error("return code missed");
  a_row0_hide: assert property (rom_bus.rd_valid && frow_pipe == 5'd0 && !is_shadow(fsub_pipe)
    |=> font_dots == 12'h000) else $error("row zero shown without shadow");
  a_row_limit: assert property (rom_bus.rd_valid && frow_pipe > 5'd18 |=>
    font_dots == 12'h000 && !font_carry) else $error("hidden row shown");

  c_store: cover property (store_ack ##1 s_axi_bvalid && s_axi_bready);
  c_wrap: cover property (store_ack && ptr_reg == 8'hff);
  c_space: cover property (disp_valid && disp_kind == OCL_KIND_SPACE);
  c_carry: cover property (font_valid && font_carry);
endmodule : ocl_loader
`default_nettype wire

// *** core/ocl_mem_if.sv ***
// write/read port between the loader and its memories
// write held until wr_ack; read data one cycle after rd_en
`timescale 1ns/10ps
`default_nettype none
interface ocl_mem_if #(parameter int WAW = 8, parameter int WDW = 12,
                       parameter int RAW = 8, parameter int RDW = 12);
  logic wr_en;
  logic [WAW-1:0] wr_addr;
  logic [WDW-1:0] wr_data;
  logic wr_ack;
  logic rd_en;
  logic [RAW-1:0] rd_addr;
  logic [RDW-1:0] rd_data;
  logic rd_valid;
  modport user (output wr_en, output wr_addr, output wr_data, input wr_ack,
                output rd_en, output rd_addr, input rd_data, input rd_valid);
  modport store (input wr_en, input wr_addr, input wr_data, output wr_ack,
                 input rd_en, input rd_addr, output rd_data, output rd_valid);
endinterface : ocl_mem_if
`default_nettype wire

// *** core/ocl_pkg.sv ***
// types and helpers shared by the loader, display ram and font rom
// assumes ocl_cfg.svh is on the include path
`include "ocl_cfg.svh"
package ocl_pkg;
  typedef enum logic [1:0] {OCL_KIND_CUSTOMER, OCL_KIND_CR, OCL_KIND_SPACE} ocl_kind_type;
  typedef enum logic [1:0] {OCL_WR_IDLE, OCL_WR_STORE, OCL_WR_RESP} ocl_wstate_type;
  typedef enum logic [2:0] {OCL_REG_NONE, OCL_REG_ATTR, OCL_REG_CODE, OCL_REG_PTR,
                            OCL_REG_FADDR, OCL_REG_FDATA, OCL_REG_STAT} ocl_reg_type;

  function automatic ocl_kind_type ocl_classify(input logic [`OCL_CODE_W-1:0] code);
    if (code == `OCL_CODE_CR) begin
      return OCL_KIND_CR;
    end
    if (code == `OCL_CODE_SPACE) begin
      return OCL_KIND_SPACE;
    end
    return OCL_KIND_CUSTOMER;
  endfunction : ocl_classify

  // byte address of a font row: 38 bytes per font, two bytes per row
  function automatic logic [`OCL_ROM_AW-1:0] ocl_font_addr(input logic [`OCL_CODE_W-1:0] code,
                                                           input logic [`OCL_ROW_W-1:0] row);
    logic [`OCL_ROM_AW-1:0] base;
    base = 13'({6'h00, code}) * `OCL_FONT_BYTES;
    return 13'(base + 13'({8'h00, row}) * `OCL_ROW_BYTES);
  endfunction : ocl_font_addr
endpackage : ocl_pkg

// *** verification/ocl_host_model.sv ***
// axi4-lite host model: one write or one read under way at a time
// assumes each call starts just after a rising edge of aclk
`timescale 1ns/10ps
`default_nettype none
`include "ocl_cfg.svh"
module ocl_host_model (
  // clock
  input wire logic aclk,
  // write side
  output logic [`OCL_AXI_AW-1:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  output logic bready,
  // read side
  output logic [`OCL_AXI_AW-1:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
  end
  task automatic wr(input logic [`OCL_AXI_AW-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (((awvalid && !awready) || (wvalid && !wready)) && n < 200);
    do begin
      @(posedge aclk);
      n++;
    end while (!bvalid && n < 400);
    bready <= 1'b0;
    if (n >= 400) test_osd_char_ram_loader.hang();
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [`OCL_AXI_AW-1:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!arready && n < 200);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      n++;
    end while (!rvalid && n < 400);
    rready <= 1'b0;
    if (n >= 400) test_osd_char_ram_loader.hang();
    @(posedge aclk);
  endtask : rd
endmodule : ocl_host_model
`default_nettype wire

// *** verification/test_osd_char_ram_loader.sv ***
// bench for the display-ram loader: registers, auto store, both fetch paths
// assumes ocl_host_model drives the axi4-lite side
`timescale 1ns/10ps
`default_nettype none
`include "ocl_cfg.svh"
module test_osd_char_ram_loader;
  import ocl_pkg::*;
  localparam logic [11:0] A_AT = 12'h264, A_CD = 12'h268, A_PT = 12'h26c;
  localparam logic [11:0] A_FA = 12'h270, A_FD = 12'h274, A_ST = 12'h278;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr, araddr, dword, fdots;
  logic [31:0] wdata, rdata;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp;
  logic drd = 1'b0, frd = 1'b0, drow, dspc, dval, fcar, fval;
  logic [7:0] dra = 8'h00, ptr = 8'h00, b;
  ocl_kind_type dkind;
  logic [6:0] fcode = 7'h00;
  logic [4:0] frow = 5'h00, attr = 5'h00;
  logic [1:0] fsub = 2'b00;
  int fails = 0, checks = 0;
  logic [35:0] rq[$], bq[$], dq[$], fq[$];
  logic [11:0] dram[256];
  logic [7:0] fbytes [6] = '{8'h81, 8'h42, 8'h81, 8'h42, 8'ha5, 8'h3c};
  ocl_loader dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .disp_rd_en(drd), .disp_rd_addr(dra), .disp_word(dword),
    .disp_kind(dkind), .disp_row_end(drow), .disp_space_clear(dspc), .disp_valid(dval),
    .font_rd_en(frd), .font_code(fcode), .font_row(frow), .font_submode(fsub),
    .font_dots(fdots), .font_carry(fcar), .font_valid(fval));
  ocl_host_model host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready));
  initial begin
    forever #2 aclk = ~aclk;
  end
  task automatic cmp(input logic [35:0] g, input logic [35:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  always @(posedge aclk) begin
    if (rvalid && rready) cmp({2'b00, rresp, rdata}, rq.pop_front());
    if (bvalid && bready) cmp({34'h0, bresp}, bq.pop_front());
    if (dval) cmp({20'h0, dkind, drow, dspc, dword}, dq.pop_front());
    if (fval) cmp({23'h0, fcar, fdots}, fq.pop_front());
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
    bq.push_back({34'h0, r});
    host.wr(a, d);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = 2'b00);
    rq.push_back({2'b00, r, d});
    host.rd(a);
  endtask : rd
  // a code write stores at the pointer, then the pointer moves on
  task automatic code(input logic [7:0] c);
    wr(A_CD, {24'h0, c});
    if (ptr < 8'd192) dram[ptr] = {c[6:0], attr};
    ptr++;
  endtask : code
  task automatic fetch(input logic [7:0] a);
    logic [11:0] w;
    logic cr, sp;
    w = (a < 8'd192) ? dram[a] : 12'h000;
    cr = w[11:5] == `OCL_CODE_CR;
    sp = w[11:5] == `OCL_CODE_SPACE;
    drd <= 1'b1;
    dra <= a;
    dq.push_back({20'h0, cr ? 2'd1 : sp ? 2'd2 : 2'd0, cr, sp && w[0], w});
    @(posedge aclk);
  endtask : fetch
  task automatic ffetch(input logic [6:0] c, input logic [4:0] r, input logic [1:0] s,
                        input logic [12:0] e);
    frd <= 1'b1;
    fcode <= c;
    frow <= r;
    fsub <= s;
    fq.push_back({23'h0, e});
    @(posedge aclk);
  endtask : ffetch
  task automatic hang();
    fails++;
    complete_run();
  endtask : hang
  task automatic complete_run();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  initial begin
    void'($urandom(32'h619f42b6));
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(A_AT, 32'h0);
    rd(A_PT, 32'h0);
    rd(12'h100, 32'h0, 2'b10);
    wr(12'h100, 32'h1, 2'b10);
    wr(A_PT, 32'hbe);
    ptr = 8'hbe;
    wr(A_AT, 32'hff);
    attr = 5'h1f;
    rd(A_AT, 32'h1f);
    code(8'hfe);
    rd(A_CD, 32'h7e);
    rd(A_PT, 32'hbf);
    wr(A_AT, 32'h01);
    attr = 5'h01;
    code(8'h7f);
    // last two land past the ram: dropped, then the pointer wraps
    wr(A_PT, 32'hfe);
    ptr = 8'hfe;
    code(8'h11);
    code(8'h12);
    rd(A_ST, 32'h2);
    rd(A_PT, 32'h0);
    fetch(8'd190);
    fetch(8'd191);
    fetch(8'd200);
    drd <= 1'b0;
    b = 8'($urandom_range(0, 180));
    wr(A_PT, {24'h0, b});
    ptr = b;
    wr(A_AT, 32'($urandom_range(0, 255)));
    attr = 5'(host.wdata);
    // attribute reused by every store; fetches compete with the first one
    fork
      code(8'($urandom));
      begin
        repeat (3) fetch(8'd190);
        drd <= 1'b0;
      end
    join
    repeat (5) code(8'($urandom));
    for (int i = 0; i < 6; i++) fetch(b + 8'(i));
    drd <= 1'b0;
    // font 0 row 18 and font 1 row 0 share a pattern, then font 1 row 1
    wr(A_FA, 32'd36);
    foreach (fbytes[i]) wr(A_FD, {24'h0, fbytes[i]});
    rd(A_FD, 32'h0);
    wr(A_FA, 32'd4182);
    wr(A_FD, 32'h5a);
    wr(A_FD, 32'hc0);
    repeat (2) wr(A_FD, 32'hff);
    wr(A_FA, 32'd4216);
    repeat (2) wr(A_FD, 32'h00);
    ffetch(7'd1, 5'd1, 2'd0, 13'h0a53);
    ffetch(7'd1, 5'd0, 2'd0, 13'h0000);
    ffetch(7'd1, 5'd0, 2'd1, 13'h0814);
    ffetch(7'd1, 5'd1, 2'd3, 13'h1a53);
    ffetch(7'd1, 5'd19, 2'd0, 13'h0000);
    ffetch(7'd110, 5'd1, 2'd0, 13'h05ac);
    ffetch(7'd0, 5'd18, 2'd0, 13'h0814);
    ffetch(7'd110, 5'd2, 2'd0, 13'h0fff);
    ffetch(7'd110, 5'd18, 2'd1, 13'h0000);
    frd <= 1'b0;
    repeat (4) @(posedge aclk);
    cmp(36'(rq.size() + bq.size() + dq.size() + fq.size()), 36'h0);
    complete_run();
  end
endmodule : test_osd_char_ram_loader
`default_nettype wire
